// ### wbbf_funnel.sv
// sequencer that funnels 16-bit master word accesses into pairs of byte transfers and byte accesses into single ones
`timescale 1ns/10ps
module wbbf_funnel (
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // from the 16-bit master
  input wire logic BUS_CLK,
  input wire logic ADDR_LATCH_STROBE,
  input wire logic MASTER_DATA_STROBE_N,
  input wire logic READ_WRITE,
  input wire logic WORD_XFER,
  input wire logic ADDR0,
  input wire logic HOLD_ACK,
  // to the master
  output logic WAIT_N,
  // to the 8-bit bus and memory
  output logic RD_N,
  output logic WR_N,
  output logic LATCHED_LOW_ADDR_BIT,
  // latch and transceiver enables
  output logic XCVR_TO_MASTER_EN,
  output logic UPPER_LATCH_EN,
  output logic WRITE_PATH_EN,
  output logic PASS_BUF_EN,
  output logic PORT_DRIVE_EN
);
  logic [wbbf_pkg::PIN_W-1:0] pins_s;
  wbbf_pkg::wbbf_step_t step_q;
  wbbf_pkg::wbbf_step_t step_d;
  logic bclk_q;
  logic lowaddr_d;
  logic rd_d;
  logic wr_d;
  logic wait_d;
  logic xm_d;
  logic upl_d;
  logic wpe_d;
  logic pass_d;
  logic port_d;

  wbbf_sync #(
    .W(wbbf_pkg::PIN_W),
    .RST_VAL(wbbf_pkg::PIN_RESET)
  ) u_sync (
    .clk(MCLK),
    .srst(SRST),
    .din({HOLD_ACK, ADDR0, WORD_XFER, READ_WRITE, MASTER_DATA_STROBE_N,
          ADDR_LATCH_STROBE, BUS_CLK}),
    .dout(pins_s)
  );

  wire bclk = pins_s[wbbf_pkg::IDX_BCLK];
  wire ale = pins_s[wbbf_pkg::IDX_ALE];
  wire dstb = ~pins_s[wbbf_pkg::IDX_DSTB_N];
  wire rw = pins_s[wbbf_pkg::IDX_RW];
  wire word = pins_s[wbbf_pkg::IDX_WORD];
  wire a0 = pins_s[wbbf_pkg::IDX_A0];
  wire hold = pins_s[wbbf_pkg::IDX_HOLD];
  wire bclk_rise = bclk & ~bclk_q;

  // cycle kinds; the master holds direction and width steady from the first slot
  wire word_rd = hold & word & ~rw;
  wire word_wr = hold & word & rw;
  wire byte_rd = hold & ~word & ~rw;
  wire byte_wr = hold & ~word & rw;

  // step decodes
  wire at_second = (step_q == wbbf_pkg::STEP_SECOND);
  wire at_hold_a = (step_q == wbbf_pkg::STEP_HOLD_A);
  wire at_even = (step_q == wbbf_pkg::STEP_EVEN);
  wire past_first = (step_q != wbbf_pkg::STEP_FIRST);
  wire first_half = at_second | at_hold_a;
  wire second_half = (step_q >= wbbf_pkg::STEP_REREAD);
  wire waiting = past_first & (step_q <= wbbf_pkg::STEP_REREAD);
  wire to_master = (step_q >= wbbf_pkg::STEP_REREAD);

  // step counter: cleared by the latch strobe, stops at the last code
  // so a long master cycle cannot wrap back into the first byte
  assign step_d = ale ? wbbf_pkg::STEP_FIRST :
                  (bclk_rise && step_q != wbbf_pkg::STEP_END) ?
                  wbbf_pkg::wbbf_step_t'(step_q + wbbf_pkg::STEP_INC) : step_q;

  // low address bit follows the first byte while the strobe is high,
  // so it is settled when the strobe falls
  wire lowaddr_first = word ? (rw ? wbbf_pkg::LOWADDR_EVEN : wbbf_pkg::LOWADDR_ODD) : a0;
  wire lowaddr_second = rw ? wbbf_pkg::LOWADDR_ODD : wbbf_pkg::LOWADDR_EVEN;
  assign lowaddr_d = ale ? lowaddr_first :
                     (hold && word && at_even) ? lowaddr_second : LATCHED_LOW_ADDR_BIT;

  // read strobe: gapped in the STEP_HOLD_B and STEP_EVEN steps for a word read
  assign rd_d = dstb & ((word_rd & (first_half | second_half)) |
                        (byte_rd & past_first));
  assign wr_d = dstb & ((word_wr & (first_half | second_half)) |
                        (byte_wr & past_first));
  assign wait_d = (word_rd | word_wr) & waiting;
  // byte read waits for the low half of the bus clock in the second slot
  assign xm_d = (byte_rd & at_second & ~bclk) |
                (word_rd & to_master);
  assign upl_d = (word_rd & at_hold_a) | (word_wr & at_second);
  assign wpe_d = (byte_wr | word_wr) & past_first;
  assign pass_d = (word_wr & first_half) | (byte_wr & past_first);
  assign port_d = word_wr & second_half;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      step_q <= wbbf_pkg::STEP_FIRST;
      bclk_q <= 1'h0;
      LATCHED_LOW_ADDR_BIT <= wbbf_pkg::LOWADDR_EVEN;
    end else begin
      step_q <= step_d;
      bclk_q <= bclk;
      LATCHED_LOW_ADDR_BIT <= lowaddr_d;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RD_N <= 1'h1;
      WR_N <= 1'h1;
      WAIT_N <= 1'h1;
    end else begin
      RD_N <= ~rd_d;
      WR_N <= ~wr_d;
      WAIT_N <= ~wait_d;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      XCVR_TO_MASTER_EN <= 1'h0;
      UPPER_LATCH_EN <= 1'h0;
      WRITE_PATH_EN <= 1'h0;
      PASS_BUF_EN <= 1'h0;
      PORT_DRIVE_EN <= 1'h0;
    end else begin
      XCVR_TO_MASTER_EN <= xm_d;
      UPPER_LATCH_EN <= upl_d;
      WRITE_PATH_EN <= wpe_d;
      PASS_BUF_EN <= pass_d;
      PORT_DRIVE_EN <= port_d;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  AST_ALE_CLEARS: assert property (ale |=> step_q == wbbf_pkg::STEP_FIRST)
    else $error("step counter not cleared by latch strobe");
  AST_STEP_ADVANCE: assert property (
    (!ale && bclk_rise && step_q != wbbf_pkg::STEP_END) |=>
    step_q == wbbf_pkg::wbbf_step_t'($past(step_q) + wbbf_pkg::STEP_INC))
    else $error("step counter did not advance on bus clock edge");
  // outputs are registered, so each check looks one edge after its decode
  AST_WORD_RD_SECOND: assert property (
    (word_rd && at_second && dstb) |=> (!RD_N && !WAIT_N))
    else $error("read strobe or wait missing in second slot");
  AST_BYTE_RD_ONLY_LATE: assert property (
    (XCVR_TO_MASTER_EN && $past(byte_rd)) |-> $past(at_second && !bclk))
    else $error("byte read drive enable outside late second slot");
  AST_BYTE_RD_PASS: assert property (
    (byte_rd && at_second && !bclk) |=> XCVR_TO_MASTER_EN)
    else $error("byte read drive enable missing");
  AST_LOWADDR_ODD_FIRST: assert property (
    (ale && word_rd) |=> LATCHED_LOW_ADDR_BIT == wbbf_pkg::LOWADDR_ODD)
    else $error("low address bit not odd in first slot");
  AST_LOWADDR_BYTE: assert property (
    (ale && hold && !word) |=> LATCHED_LOW_ADDR_BIT == $past(a0))
    else $error("low address bit does not follow byte address");
  AST_RD_GAP: assert property (
    (word_rd && step_q == wbbf_pkg::STEP_HOLD_B) |=> RD_N)
    else $error("read strobe not negated between bytes");
  AST_RD_AGAIN: assert property (
    (word_rd && step_q == wbbf_pkg::STEP_REREAD && dstb) |=> !RD_N)
    else $error("read strobe not asserted again for even byte");
  AST_UPPER_LATCH: assert property (
    (word_rd && at_hold_a) |=> UPPER_LATCH_EN)
    else $error("upper latch enable missing in step 010");
  AST_UPPER_CAPTURE: assert property (
    (word_rd && step_q == wbbf_pkg::STEP_HOLD_B) |=> !UPPER_LATCH_EN)
    else $error("upper latch enable still high after capture");
  AST_ODD_UNTIL_CAPTURE: assert property (
    (word_rd && step_q == wbbf_pkg::STEP_HOLD_B) |=>
    LATCHED_LOW_ADDR_BIT == wbbf_pkg::LOWADDR_ODD)
    else $error("low address bit left odd byte before capture");
  AST_EVEN_BEFORE_RD: assert property (
    ($fell(RD_N) && $past(word_rd) && $past(step_q) >= wbbf_pkg::STEP_EVEN) |->
    LATCHED_LOW_ADDR_BIT == wbbf_pkg::LOWADDR_EVEN)
    else $error("read strobe returned before even byte selected");
  AST_WORD_DRIVE: assert property (
    (word_rd && step_q == wbbf_pkg::STEP_REREAD) |=> (XCVR_TO_MASTER_EN && !WAIT_N))
    else $error("assembled word not driven while master waits");
  AST_WAIT_RELEASE: assert property (
    (word_rd && step_q == wbbf_pkg::STEP_DRIVE) |=> (WAIT_N && XCVR_TO_MASTER_EN))
    else $error("wait not released with word driven");

  AST_WR_WAIT_RELEASE: assert property (
    (word_wr && step_q == wbbf_pkg::STEP_DRIVE) |=> WAIT_N)
    else $error("wait not released at end of word write");
  AST_WR_SECOND: assert property (
    (word_wr && step_q == wbbf_pkg::STEP_REREAD) |=> (PORT_DRIVE_EN && !PASS_BUF_EN))
    else $error("second write byte not from latch");
  AST_WR_ODD_SECOND: assert property (
    (word_wr && at_even) |=> LATCHED_LOW_ADDR_BIT == wbbf_pkg::LOWADDR_ODD)
    else $error("second write byte not at odd address");
  AST_WR_FIRST: assert property (
    (word_wr && at_second) |=> (PASS_BUF_EN && UPPER_LATCH_EN && !PORT_DRIVE_EN))
    else $error("first write byte not passed through");
  AST_BYTE_WR: assert property (
    (byte_wr && at_second && dstb) |=> (!WR_N && WRITE_PATH_EN))
    else $error("byte write strobe or path enable missing");
  AST_STEP_SATURATE: assert property (
    (!ale && step_q == wbbf_pkg::STEP_END) |=> step_q == wbbf_pkg::STEP_END)
    else $error("step counter wrapped past its last code");

  COV_WORD_READ: cover property (word_rd && step_q == wbbf_pkg::STEP_DRIVE);
  COV_BYTE_READ: cover property (byte_rd && XCVR_TO_MASTER_EN);
  COV_ODD_BYTE_READ: cover property (byte_rd && a0 && XCVR_TO_MASTER_EN);
  COV_WORD_WRITE: cover property (word_wr && PORT_DRIVE_EN && !WR_N);
  COV_BYTE_WRITE: cover property (byte_wr && WRITE_PATH_EN && !WR_N);
endmodule : wbbf_funnel

// ### wbbf_pkg.sv
// constants and step codes for the word-to-byte bus funnel
package wbbf_pkg;
  localparam int STEP_W = 3;
  typedef logic [STEP_W-1:0] wbbf_step_t;
  localparam wbbf_step_t STEP_FIRST = 3'h0;
  localparam wbbf_step_t STEP_SECOND = 3'h1;
  localparam wbbf_step_t STEP_HOLD_A = 3'h2;
  localparam wbbf_step_t STEP_HOLD_B = 3'h3;
  localparam wbbf_step_t STEP_EVEN = 3'h4;
  localparam wbbf_step_t STEP_REREAD = 3'h5;
  localparam wbbf_step_t STEP_DRIVE = 3'h6;
  localparam wbbf_step_t STEP_END = 3'h7;
  localparam wbbf_step_t STEP_INC = 3'h1;
  // low address bit values
  localparam logic LOWADDR_ODD = 1'h1;
  localparam logic LOWADDR_EVEN = 1'h0;
  // positions of the pins in the synchroniser vector
  localparam int PIN_W = 7;
  localparam int IDX_BCLK = 0;
  localparam int IDX_ALE = 1;
  localparam int IDX_DSTB_N = 2;
  localparam int IDX_RW = 3;
  localparam int IDX_WORD = 4;
  localparam int IDX_A0 = 5;
  localparam int IDX_HOLD = 6;
  localparam logic [PIN_W-1:0] PIN_RESET = 7'h04;
endpackage : wbbf_pkg

// ### wbbf_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module wbbf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // pins and their synchronised copies
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // the first stage feeds only the second one
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : wbbf_sync

// ### wbbf_master.sv
// behavioural 16-bit bus master that paces the funnel one bus clock phase at a time
`timescale 1ns/10ps
module wbbf_master (
  // clock
  input wire logic MCLK,
  // master pins
  output logic BUS_CLK,
  output logic ADDR_LATCH_STROBE,
  output logic MASTER_DATA_STROBE_N,
  output logic READ_WRITE,
  output logic WORD_XFER,
  output logic ADDR0,
  output logic HOLD_ACK,
  // wait back from the funnel
  input wire logic WAIT_N
);
  // phase length in MCLK; 3 or more, or the synchroniser can miss a phase
  int ph = 8;
  initial begin
    {BUS_CLK, ADDR_LATCH_STROBE, MASTER_DATA_STROBE_N, READ_WRITE, WORD_XFER, ADDR0,
      HOLD_ACK} = 7'h10;
  end

  task automatic half(input logic lvl);
    @(negedge MCLK);
    BUS_CLK = lvl;
    if (!lvl) begin
      // strobe drops and data strobe asserts only while the bus clock is low
      ADDR_LATCH_STROBE = 1'h0;
      MASTER_DATA_STROBE_N = 1'h0;
    end
    repeat (ph - 1) @(negedge MCLK);
  endtask : half

  task automatic open_cycle(input logic word, input logic rw, input logic a0, input logic hold);
    @(negedge MCLK);
    {ADDR_LATCH_STROBE, MASTER_DATA_STROBE_N} = 2'h3;
    {READ_WRITE, WORD_XFER, ADDR0, HOLD_ACK} = {rw, word, a0, hold};
    repeat (ph - 1) @(negedge MCLK);
    half(1'b1);
  endtask : open_cycle

  task automatic close_cycle(output logic late);
    int n;
    n = 0;
    // bounded, so a wait that never lifts cannot hang the master; the caller counts it
    while (WAIT_N !== 1'h1 && n < 40) begin
      @(negedge MCLK);
      n++;
    end
    late = (n >= 40);
    @(negedge MCLK);
    {BUS_CLK, MASTER_DATA_STROBE_N} = 2'h1;
    repeat (ph) @(negedge MCLK);
  endtask : close_cycle

  // byte order of the 8-bit cpu on slave register access: writes odd first, reads even first
  function automatic logic slave_a0(input logic wr, input int idx);
    return wr ? (idx == 0) : (idx != 0);
  endfunction : slave_a0
endmodule : wbbf_master

// ### wbbf_funnel_tb.sv
// self-checking bench for the word-to-byte bus funnel
`timescale 1ns/10ps
module wbbf_funnel_tb;
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic bus_clk, ale, dstb_n, rw, word, a0, hold;
  logic wait_n, rd_n, wr_n, lowaddr, xen, upl, wpe, pbe, pde;
  int miscompares = 0;
  int n_tests = 0;
  wire logic [8:0] obs = {~rd_n, ~wr_n, ~wait_n, xen, upl, wpe, pbe, pde, lowaddr};

  wbbf_master m (.MCLK(mclk), .BUS_CLK(bus_clk), .ADDR_LATCH_STROBE(ale),
    .MASTER_DATA_STROBE_N(dstb_n), .READ_WRITE(rw), .WORD_XFER(word), .ADDR0(a0),
    .HOLD_ACK(hold), .WAIT_N(wait_n));
  wbbf_funnel DUT (.MCLK(mclk), .SRST(srst), .BUS_CLK(bus_clk), .ADDR_LATCH_STROBE(ale),
    .MASTER_DATA_STROBE_N(dstb_n), .READ_WRITE(rw), .WORD_XFER(word), .ADDR0(a0),
    .HOLD_ACK(hold), .WAIT_N(wait_n), .RD_N(rd_n), .WR_N(wr_n), .LATCHED_LOW_ADDR_BIT(lowaddr),
    .XCVR_TO_MASTER_EN(xen), .UPPER_LATCH_EN(upl), .WRITE_PATH_EN(wpe), .PASS_BUF_EN(pbe),
    .PORT_DRIVE_EN(pde));

  initial begin
    forever #2 mclk = ~mclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // kind is {word, write, a0, hold}; each vector holds one bit per step 0..7
  task automatic run(input logic [3:0] kind, input logic [7:0] rdv, input logic [7:0] wrv,
    input logic [7:0] wtv, input logic [7:0] xv, input logic [7:0] ulv, input logic [7:0] wpv,
    input logic [7:0] pbv, input logic [7:0] pdv, input logic [7:0] lav);
    logic late;
    m.open_cycle(kind[3], kind[2], kind[1], kind[0]);
    for (int s = 0; s < 8; s++) begin
      if (s > 0) begin
        m.half(1'h0);
        // byte read drive comes only in the low half of step 001
        if (s == 2 && kind[3:2] == 2'h0 && kind[0]) begin
          chk("byte read late drive", {8'h90, kind[1]}, obs);
        end
        m.half(1'h1);
      end
      chk($sformatf("kind %h step %0d", kind, s), {rdv[s], wrv[s], wtv[s], xv[s], ulv[s],
        wpv[s], pbv[s], pdv[s], lav[s]}, obs);
    end
    m.close_cycle(late);
    chk("wait release in time", 9'h000, {8'h00, late});
  endtask : run

  task automatic t_word_read(input int pace);
    m.ph = pace;
    run(4'h9, 8'hE6, 8'h00, 8'h3E, 8'hE0, 8'h04, 8'h00, 8'h00, 8'h00, 8'h0F);
    m.ph = 8;
  endtask : t_word_read

  task automatic t_word_write();
    run(4'hD, 8'h00, 8'hE6, 8'h3E, 8'h00, 8'h02, 8'hFE, 8'h06, 8'hE0, 8'hF0);
  endtask : t_word_write

  task automatic t_byte_read();
    logic [3:0] kind;
    // two byte reads in the order the 8-bit cpu uses for slave reads
    for (int i = 0; i < 2; i++) begin
      kind = {2'h0, m.slave_a0(1'h0, i), 1'h1};
      run(kind, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, {8{kind[1]}});
    end
  endtask : t_byte_read

  task automatic t_byte_write();
    logic [3:0] kind;
    // two byte writes in the order the 8-bit cpu uses for slave writes
    for (int i = 0; i < 2; i++) begin
      kind = {2'h1, m.slave_a0(1'h1, i), 1'h1};
      run(kind, 8'h00, 8'hFE, 8'h00, 8'h00, 8'h00, 8'hFE, 8'hFE, 8'h00, {8{kind[1]}});
    end
  endtask : t_byte_write

  task automatic t_no_hold();
    // without bus ownership no strobe or enable reaches the byte bus;
    // the address bit still follows the latch strobe
    run(4'h8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF);
  endtask : t_no_hold

  initial begin
    repeat (6) @(negedge mclk);
    srst = 1'h0;
    t_word_read(8);
    t_word_write();
    t_byte_read();
    t_byte_write();
    t_no_hold();
    t_word_read(12);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("ERROR watchdog expected done seen hang");
    end_of_test();
  end
endmodule : wbbf_funnel_tb
